// ---- common/mcs_pkg.sv ----
// constants shared by the memory checksum scanner and its crc engine
// assumes one peripheral clock and byte-wide register access
package mcs_pkg;

  // register offsets on the plain register port
  localparam logic [1:0] ADDR_SCAN_CONTROL       = 2'h0;
  localparam logic [1:0] ADDR_SCAN_SOURCE_SELECT = 2'h1;
  localparam logic [1:0] ADDR_SCAN_STATE         = 2'h2;

  // field positions
  localparam int BIT_STROBE_RESET = 7;
  localparam int BIT_FAILURE_ARM  = 1;
  localparam int BIT_ENABLE       = 0;
  localparam int BIT_PASS         = 1;
  localparam int BIT_BUSY         = 0;

  // values after reset
  localparam logic [7:0] SCAN_CONTROL_RESET       = 8'h00;
  localparam logic [7:0] SCAN_SOURCE_SELECT_RESET = 8'h00;
  localparam logic [7:0] SCAN_STATE_RESET         = 8'h02;

  // region_field encodings
  localparam logic [1:0] REGION_WHOLE_FLASH           = 2'h0;
  localparam logic [1:0] REGION_BOOT_PLUS_APPLICATION = 2'h1;
  localparam logic [1:0] REGION_BOOT                  = 2'h2;
  localparam logic [1:0] REGION_SIGNATURE_ROW         = 2'h3;

  // cycle counts
  localparam logic [1:0] START_DELAY_CYCLES = 2'h3;
  localparam logic [1:0] WORD_FETCH_CYCLES  = 2'h3;

  // ccitt checksum
  localparam logic [15:0] CRC_INIT    = 16'hffff;
  localparam logic [15:0] CRC_POLY    = 16'h1021;
  localparam logic [15:0] CRC_RESIDUE = 16'h0000;

  // scan sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WAIT,
    ST_FETCH,
    ST_TAKE,
    ST_CHECK
  } mcs_state_type;

endpackage : mcs_pkg

// ---- hdl/mcs_crc16.sv ----
// ccitt 16-bit checksum engine, two bytes per fed word
// assumes the word is fed in the cycle its data are valid
`timescale 1ns/1ps
module mcs_crc16 (
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  input  wire logic        i_init,
  input  wire logic        i_feed,
  input  wire logic [15:0] i_word,
  output logic      [15:0] o_crc
);

  logic [15:0] crc_reg;
  logic [15:0] crc_next;

  // one byte through the shift register, msb first
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--)
    begin
      if (r[15] ^ b[i])
        r = {r[14:0], 1'b0} ^ mcs_pkg::CRC_POLY;
      else
        r = {r[14:0], 1'b0};
    end
    return r;
  endfunction : crc_byte

  // byte 0 is the low lane of the word
  assign crc_next = crc_byte(crc_byte(crc_reg, i_word[7:0]), i_word[15:8]);

  // checksum register
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      crc_reg <= mcs_pkg::CRC_INIT;
    else if (i_init)
      crc_reg <= mcs_pkg::CRC_INIT;
    else if (i_feed)
      crc_reg <= crc_next;
  end

  assign o_crc = crc_reg;

endmodule : mcs_crc16

// ---- hdl/mcs_scanner.sv ----
// memory checksum scanner: control registers, scan sequencer, flash reads
// assumes flash data valid while the read pulse is high
`timescale 1ns/1ps
module mcs_scanner #(
  parameter int          AW             = 13,
  parameter logic [12:0] FLASH_LAST_WORD = 13'h1fff,
  parameter logic [12:0] SIGNATURE_ROW_LAST_WORD = 13'h001f
) (
  input  wire logic          i_clock,
  input  wire logic          i_rst_n,
  input  wire logic [1:0]    i_addr,
  input  wire logic [7:0]    i_wdata,
  input  wire logic          i_wr,
  input  wire logic          i_rd,
  output logic      [7:0]    o_rdata,
  input  wire logic          i_boot_scan_en,
  input  wire logic [1:0]    i_boot_scan_src,
  input  wire logic [AW-1:0] i_boot_last_word,
  input  wire logic [AW-1:0] i_app_last_word,
  output logic               o_flash_rd,
  output logic      [AW-1:0] o_flash_addr,
  output logic               o_flash_signature_row,
  input  wire logic [15:0]   i_flash_data,
  output logic               o_cpu_stall,
  output logic               o_nmi_req,
  output logic               o_busy
);

  mcs_pkg::mcs_state_type state_reg;
  logic          enable_reg;
  logic          arm_reg;
  logic [1:0]    src_reg;
  logic          busy_reg;
  logic          pass_reg;
  logic          nmi_reg;
  logic          rst_pend_reg;
  logic          boot_done_reg;
  logic [1:0]    wait_reg;
  logic [1:0]    div_reg;
  logic [AW-1:0] word_reg;
  logic [AW-1:0] last_reg;
  logic [7:0]    rdata_reg;
  logic          rd_reg;
  logic          signature_row_reg;
  logic          stall_reg;
  logic [15:0]   crc_value;
  // register write decode
  wire ctrl_wr    = i_wr && (i_addr == mcs_pkg::ADDR_SCAN_CONTROL);
  wire src_wr     = i_wr && (i_addr == mcs_pkg::ADDR_SCAN_SOURCE_SELECT);
  wire ctrl_open  = ctrl_wr && !nmi_reg && !rst_pend_reg;
  wire rst_req    = ctrl_open && i_wdata[mcs_pkg::BIT_STROBE_RESET];
  wire rst_acc    = rst_req && (!arm_reg || !busy_reg);
  wire sw_launch  = ctrl_open && i_wdata[mcs_pkg::BIT_ENABLE] && !rst_acc;
  wire boot_launch = !boot_done_reg && i_boot_scan_en;
  wire launch     = sw_launch || boot_launch;
  wire arm_set    = ctrl_open && i_wdata[mcs_pkg::BIT_FAILURE_ARM] && !busy_reg;
  wire src_open   = src_wr && !busy_reg && !nmi_reg && !rst_pend_reg;
  // sequencer decode
  wire wait_done  = (state_reg == mcs_pkg::ST_WAIT) && (wait_reg == 2'h0);
  wire tick       = (div_reg == 2'h0);
  wire in_check   = (state_reg == mcs_pkg::ST_CHECK);
  wire scan_pass  = (crc_value == mcs_pkg::CRC_RESIDUE);
  wire last_word  = (word_reg == last_reg);
  // section end by region
  wire [AW-1:0] section_last =
    (src_reg == mcs_pkg::REGION_WHOLE_FLASH)           ? FLASH_LAST_WORD[AW-1:0] :
    (src_reg == mcs_pkg::REGION_BOOT_PLUS_APPLICATION) ? i_app_last_word :
    (src_reg == mcs_pkg::REGION_BOOT)                  ? i_boot_last_word :
                                                         SIGNATURE_ROW_LAST_WORD[AW-1:0];
  // read mux, state register has no write path
  wire [7:0] ctrl_view  = {6'h00, arm_reg, enable_reg};
  wire [7:0] src_view   = {6'h00, src_reg};
  wire [7:0] state_view = {6'h00, pass_reg, busy_reg};
  wire [7:0] read_mux =
    (i_addr == mcs_pkg::ADDR_SCAN_CONTROL)       ? ctrl_view :
    (i_addr == mcs_pkg::ADDR_SCAN_SOURCE_SELECT) ? src_view :
    (i_addr == mcs_pkg::ADDR_SCAN_STATE)         ? state_view : 8'h00;
  // read data one cycle after the strobe
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      rdata_reg <= 8'h00;
    else
      rdata_reg <= i_rd ? read_mux : 8'h00;
  end
  // start-up scan capture after reset release
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      boot_done_reg <= 1'b0;
    else
      boot_done_reg <= 1'b1;
  end
  // strobe reset pending, never stored as a bit
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      rst_pend_reg <= 1'b0;
    else
      rst_pend_reg <= rst_acc;
  end
  // enable bit
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      enable_reg <= mcs_pkg::SCAN_CONTROL_RESET[mcs_pkg::BIT_ENABLE];
    else if (rst_pend_reg)
      enable_reg <= 1'b0;
    else if (boot_launch)
      enable_reg <= 1'b1;
    else if (ctrl_open && !rst_acc)
      enable_reg <= i_wdata[mcs_pkg::BIT_ENABLE];
  end
  // failure interrupt arm, only system reset clears it
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      arm_reg <= mcs_pkg::SCAN_CONTROL_RESET[mcs_pkg::BIT_FAILURE_ARM];
    else if (arm_set)
      arm_reg <= 1'b1;
  end
  // region field
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      src_reg <= mcs_pkg::SCAN_SOURCE_SELECT_RESET[1:0];
    else if (rst_pend_reg)
      src_reg <= 2'h0;
    else if (boot_launch)
      src_reg <= i_boot_scan_src;
    else if (src_open)
      src_reg <= i_wdata[1:0];
  end
  // busy and pass flags
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      busy_reg <= mcs_pkg::SCAN_STATE_RESET[mcs_pkg::BIT_BUSY];
      pass_reg <= mcs_pkg::SCAN_STATE_RESET[mcs_pkg::BIT_PASS];
    end
    else if (rst_pend_reg)
    begin
      busy_reg <= 1'b0;
      pass_reg <= 1'b0;
    end
    else if (launch)
    begin
      busy_reg <= 1'b1;
      pass_reg <= 1'b0;
    end
    else if (in_check)
    begin
      busy_reg <= 1'b0;
      pass_reg <= scan_pass;
    end
  end
  // sticky failure interrupt
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      nmi_reg <= 1'b0;
    else if (in_check && !scan_pass && arm_reg)
      nmi_reg <= 1'b1;
  end
  // scan sequencer
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      state_reg <= mcs_pkg::ST_IDLE;
    else if (rst_pend_reg)
      state_reg <= mcs_pkg::ST_IDLE;
    else if (launch)
      state_reg <= mcs_pkg::ST_WAIT;
    else
    begin
      case (state_reg)
        mcs_pkg::ST_IDLE:  state_reg <= mcs_pkg::ST_IDLE;
        mcs_pkg::ST_WAIT:  state_reg <= wait_done ? mcs_pkg::ST_FETCH : mcs_pkg::ST_WAIT;
        mcs_pkg::ST_FETCH: state_reg <= tick ? mcs_pkg::ST_TAKE : mcs_pkg::ST_FETCH;
        mcs_pkg::ST_TAKE:  state_reg <= last_word ? mcs_pkg::ST_CHECK : mcs_pkg::ST_FETCH;
        mcs_pkg::ST_CHECK: state_reg <= mcs_pkg::ST_IDLE;
        default:           state_reg <= mcs_pkg::ST_IDLE;
      endcase
    end
  end
  // start delay and word-rate divider
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wait_reg <= 2'h0;
      div_reg  <= 2'h0;
    end
    else
    begin
      wait_reg <= launch ? (mcs_pkg::START_DELAY_CYCLES - 2'h1) :
                  (wait_reg != 2'h0) ? (wait_reg - 2'h1) : 2'h0;
      div_reg  <= (wait_done || div_reg == (mcs_pkg::WORD_FETCH_CYCLES - 2'h1)) ? 2'h0 :
                  (div_reg + 2'h1);
    end
  end
  // word address and section end
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      word_reg <= '0;
      last_reg <= '0;
    end
    else if (wait_done)
    begin
      word_reg <= '0;
      last_reg <= section_last;
    end
    else if (state_reg == mcs_pkg::ST_TAKE && !last_word)
      word_reg <= word_reg + 1'b1;
  end
  // flash port and processor stall
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rd_reg     <= 1'b0;
      signature_row_reg <= 1'b0;
      stall_reg  <= 1'b0;
    end
    else
    begin
      rd_reg <= (state_reg == mcs_pkg::ST_FETCH) && tick && !rst_pend_reg && !launch;
      if (wait_done)
        signature_row_reg <= (src_reg == mcs_pkg::REGION_SIGNATURE_ROW);
      if (rst_pend_reg || launch || in_check)
        stall_reg <= 1'b0;
      else if (wait_done)
        stall_reg <= 1'b1;
    end
  end
  // checksum engine
  mcs_crc16 u_crc (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .i_init  (wait_done),
    .i_feed  (state_reg == mcs_pkg::ST_TAKE),
    .i_word  (i_flash_data),
    .o_crc   (crc_value)
  );
  assign o_rdata        = rdata_reg;
  assign o_flash_rd     = rd_reg;
  assign o_flash_addr   = word_reg;
  assign o_flash_signature_row = signature_row_reg;
  assign o_cpu_stall    = stall_reg;
  assign o_nmi_req      = nmi_reg;
  assign o_busy         = busy_reg;
  // checks
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);
  sequence s_quiet_start;
    (!o_cpu_stall) [*3];
  endsequence
  sequence s_clear_after;
    rst_pend_reg ##1 (!enable_reg && src_reg == 2'h0 && !busy_reg && !pass_reg);
  endsequence
  property p_strobe_clear;
    rst_acc |=> s_clear_after;
  endproperty
  a_strobe_clear: assert property (p_strobe_clear) else $error("strobe reset did not clear");
  property p_reset_refused;
    (rst_req && arm_reg && busy_reg) |=> !rst_pend_reg;
  endproperty
  a_reset_refused: assert property (p_reset_refused) else $error("armed busy reset taken");
  property p_nmi_on_fail;
    (in_check && !scan_pass && arm_reg) |=> o_nmi_req && !pass_reg;
  endproperty
  a_nmi_on_fail: assert property (p_nmi_on_fail) else $error("mismatch raised no interrupt");
  property p_arm_sticky;
    arm_reg |=> arm_reg;
  endproperty
  a_arm_sticky: assert property (p_arm_sticky) else $error("arm bit cleared");
  property p_arm_guard;
    (!arm_reg && ctrl_wr && i_wdata[1] && busy_reg) |=> !arm_reg;
  endproperty
  a_arm_guard: assert property (p_arm_guard) else $error("arm set while busy");
  property p_ctrl_locked;
    (nmi_reg && ctrl_wr) |=> $stable(enable_reg) && !rst_pend_reg;
  endproperty
  a_ctrl_locked: assert property (p_ctrl_locked) else $error("control written after interrupt");
  property p_src_locked;
    (src_wr && (busy_reg || nmi_reg) && !rst_pend_reg && !boot_launch) |=> $stable(src_reg);
  endproperty
  a_src_locked: assert property (p_src_locked) else $error("source written while locked");
  property p_start_delay;
    (launch && !rst_pend_reg) |=> s_quiet_start ##1 o_cpu_stall;
  endproperty
  a_start_delay: assert property (p_start_delay) else $error("scan start delay wrong");
  property p_busy_pass;
    o_busy |-> !pass_reg;
  endproperty
  a_busy_pass: assert property (p_busy_pass) else $error("pass flag high while busy");
  property p_word_rate;
    o_flash_rd |=> !o_flash_rd ##1 !o_flash_rd;
  endproperty
  a_word_rate: assert property (p_word_rate) else $error("flash read faster than rate");
  property p_nmi_held;
    o_nmi_req |=> o_nmi_req;
  endproperty
  a_nmi_held: assert property (p_nmi_held) else $error("interrupt request dropped");

endmodule : mcs_scanner

// ---- test/mcs_flash_model.sv ----
// flash read port model: main array and signature row array
// assumes registered read pulses; data stand within the pulse cycle
`timescale 1ns/1ps
module mcs_flash_model (
  input  wire logic        i_rd,
  input  wire logic [12:0] i_addr,
  input  wire logic        i_signature_row,
  output logic      [15:0] o_data
);
  logic [15:0] main_mem [8];
  logic [15:0] sig_mem  [4];
  logic [15:0] word_sel;

  // addressed word from the selected space
  assign word_sel = i_signature_row ? sig_mem[i_addr[1:0]] : main_mem[i_addr[2:0]];

  // word stands during the read pulse, its inverse otherwise
  assign o_data = i_rd ? word_sel : ~word_sel;
endmodule : mcs_flash_model

// ---- test/testbench.sv ----
// self-checking bench for the memory checksum scanner
// assumes the flash model on the read port and short sections
`timescale 1ns/1ps
module testbench;
  logic        i_clock;
  logic        i_rst_n;
  logic [1:0]  i_addr;
  logic [7:0]  i_wdata;
  logic        i_wr;
  logic        i_rd;
  logic [7:0]  o_rdata;
  logic        i_boot_scan_en;
  logic [1:0]  i_boot_scan_src;
  logic        o_flash_rd;
  logic [12:0] o_flash_addr;
  logic        o_flash_signature_row;
  logic [15:0] i_flash_data;
  logic        o_cpu_stall;
  logic        o_nmi_req;
  logic        o_busy;
  int          n_mismatch = 0;
  int          checked = 0;
  int          rd_cnt = 0;
  int          cyc = 0;
  int          last_cyc = 0;
  logic        mon_on;
  logic [1:0]  cur_src;
  // last word per region code: whole, boot+app, boot, signature
  logic [12:0] last_word [4] = '{13'h0007, 13'h0005, 13'h0003, 13'h0003};
  // rows: region, corrupt flag, expected state after the scan
  logic [1:0]  row_src [6] = '{2'h3, 2'h2, 2'h1, 2'h3, 2'h0, 2'h0};
  logic        row_bad [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
  logic [7:0]  row_exp [6] = '{8'h02, 8'h02, 8'h02, 8'h00, 8'h00, 8'h02};

  mcs_scanner #(
    .FLASH_LAST_WORD  (13'h0007),
    .SIGNATURE_ROW_LAST_WORD (13'h0003)
  ) mcs_scanner_inst (
    .i_clock          (i_clock),
    .i_rst_n          (i_rst_n),
    .i_addr           (i_addr),
    .i_wdata          (i_wdata),
    .i_wr             (i_wr),
    .i_rd             (i_rd),
    .o_rdata          (o_rdata),
    .i_boot_scan_en   (i_boot_scan_en),
    .i_boot_scan_src  (i_boot_scan_src),
    .i_boot_last_word (13'h0003),
    .i_app_last_word  (13'h0005),
    .o_flash_rd       (o_flash_rd),
    .o_flash_addr     (o_flash_addr),
    .o_flash_signature_row   (o_flash_signature_row),
    .i_flash_data     (i_flash_data),
    .o_cpu_stall      (o_cpu_stall),
    .o_nmi_req        (o_nmi_req),
    .o_busy           (o_busy)
  );

  mcs_flash_model mcs_flash_model_inst (
    .i_rd     (o_flash_rd),
    .i_addr   (o_flash_addr),
    .i_signature_row (o_flash_signature_row),
    .o_data   (i_flash_data)
  );

  task automatic ck(input string what, input logic [7:0] exp, input logic [7:0] seen);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : ck

  task automatic cp(input string what, input logic exp, input logic seen);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %b seen %b", what, exp, seen);
    end
  endtask : cp

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rc(input logic [1:0] a, input logic [7:0] exp);
    @(posedge i_clock);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1;
    ck($sformatf("reg %0d", a), exp, o_rdata);
  endtask : rc

  task automatic wait_idle();
    int k;
    k = 0;
    #1;
    while (o_busy !== 1'b0 && k < 300)
    begin
      @(posedge i_clock);
      #1;
      k++;
    end
    cp("busy end", 1'b0, o_busy);
  endtask : wait_idle

  task automatic sys_reset();
    i_rst_n <= 1'b0;
    repeat (6) @(posedge i_clock);
    i_rst_n <= 1'b1;
  endtask : sys_reset

  // ccitt step over one byte, msb first
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? mcs_pkg::CRC_POLY : 16'h0000);
    return c;
  endfunction : crc_byte

  // fill flash, seal each section high byte first, optionally corrupt
  task automatic load_mem(input logic bad);
    logic [15:0] c;
    for (int i = 0; i < 8; i++)
      mcs_flash_model_inst.main_mem[i] = 16'(16'h1357 * (i + 1));
    for (int i = 0; i < 4; i++)
      mcs_flash_model_inst.sig_mem[i] = 16'(16'hace1 + i);
    for (int s = 2; s >= 0; s--)
    begin
      c = mcs_pkg::CRC_INIT;
      for (int i = 0; i < int'(last_word[s]); i++)
        c = crc_byte(crc_byte(c, mcs_flash_model_inst.main_mem[i][7:0]),
                     mcs_flash_model_inst.main_mem[i][15:8]);
      mcs_flash_model_inst.main_mem[last_word[s]] = {c[7:0], c[15:8]};
    end
    c = mcs_pkg::CRC_INIT;
    for (int i = 0; i < 3; i++)
      c = crc_byte(crc_byte(c, mcs_flash_model_inst.sig_mem[i][7:0]),
                   mcs_flash_model_inst.sig_mem[i][15:8]);
    mcs_flash_model_inst.sig_mem[3] = {c[7:0], c[15:8]};
    mcs_flash_model_inst.main_mem[0][4] ^= bad;
    mcs_flash_model_inst.sig_mem[0][4] ^= bad;
  endtask : load_mem

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  // clock at 4 ns period
  initial
  begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end

  // flash read order, spacing and space select during table scans
  always @(posedge i_clock)
  begin
    cyc++;
    if (mon_on && o_flash_rd === 1'b1)
    begin
      cp("flash addr", 1'b1, o_flash_addr === 13'(rd_cnt));
      cp("signature_row", cur_src == 2'h3, o_flash_signature_row);
      cp("stall", 1'b1, o_cpu_stall);
      if (rd_cnt > 0)
        ck("spacing", 8'h03, 8'(cyc - last_cyc));
      rd_cnt++;
      last_cyc = cyc;
    end
  end

  // watchdog far beyond the few hundred cycles of the run
  initial
  begin
    repeat (20000) @(posedge i_clock);
    n_mismatch++;
    tally_and_finish();
  end

  // main sequence
  initial
  begin
    i_rst_n = 1'b0;
    i_addr = 2'h0;
    i_wdata = 8'h00;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_boot_scan_en = 1'b0;
    i_boot_scan_src = 2'h0;
    mon_on = 1'b0;
    cur_src = 2'h0;
    load_mem(1'b0);
    sys_reset();
    rc(2'h0, 8'h00);
    rc(2'h1, 8'h00);
    rc(2'h2, 8'h02);
    rc(2'h3, 8'h00);
    wr(2'h2, 8'hff);
    rc(2'h2, 8'h02);
    for (int r = 0; r < 6; r++)
    begin
      load_mem(row_bad[r]);
      cur_src = row_src[r];
      rd_cnt = 0;
      mon_on = 1'b1;
      wr(2'h1, {6'h00, cur_src});
      wr(2'h0, 8'h01);
      wait_idle();
      mon_on = 1'b0;
      ck("reads", 8'(last_word[cur_src] + 13'h0001), 8'(rd_cnt));
      rc(2'h2, row_exp[r]);
      rc(2'h0, 8'h01);
      cp("nmi", 1'b0, o_nmi_req);
      cp("stall", 1'b0, o_cpu_stall);
    end
    // start delay, then refused writes and strobe reset while busy
    load_mem(1'b0);
    wr(2'h0, 8'h01);
    #1;
    cp("busy", 1'b1, o_busy);
    repeat (3)
    begin
      cp("stall", 1'b0, o_cpu_stall);
      @(posedge i_clock);
      #1;
    end
    cp("stall", 1'b1, o_cpu_stall);
    rc(2'h2, 8'h01);
    wr(2'h1, 8'h03);
    rc(2'h1, 8'h00);
    wr(2'h0, 8'h03);
    rc(2'h0, 8'h01);
    wr(2'h0, 8'h80);
    rc(2'h2, 8'h00);
    rc(2'h0, 8'h00);
    cp("busy", 1'b0, o_busy);
    // armed unit: strobe reset when idle and when busy
    wr(2'h0, 8'h02);
    rc(2'h0, 8'h02);
    wr(2'h0, 8'h80);
    rc(2'h0, 8'h02);
    wr(2'h0, 8'h03);
    wr(2'h0, 8'h80);
    rc(2'h2, 8'h01);
    rc(2'h0, 8'h02);
    wait_idle();
    rc(2'h2, 8'h02);
    // failing scan disabled during its start delay still raises the interrupt
    load_mem(1'b1);
    wr(2'h0, 8'h03);
    wr(2'h0, 8'h02);
    wait_idle();
    cp("nmi", 1'b1, o_nmi_req);
    rc(2'h2, 8'h00);
    wr(2'h0, 8'h01);
    rc(2'h0, 8'h02);
    cp("busy", 1'b0, o_busy);
    wr(2'h1, 8'h01);
    rc(2'h1, 8'h00);
    cp("nmi", 1'b1, o_nmi_req);
    // start-up scan of the boot section
    load_mem(1'b0);
    i_boot_scan_en <= 1'b1;
    i_boot_scan_src <= 2'h2;
    sys_reset();
    rc(2'h0, 8'h01);
    rc(2'h1, 8'h02);
    cp("nmi", 1'b0, o_nmi_req);
    wait_idle();
    rc(2'h2, 8'h02);
    tally_and_finish();
  end
endmodule : testbench
